// ==== shared/fpk_defs.vh ====
`ifndef FPK_DEFS_VH
`define FPK_DEFS_VH

// Clock rate and derived cycle counts.
`define FPK_CLK_KHZ 200000
`define FPK_CLK_NS 5
`define FPK_DEB_MS 5
`define FPK_DEB_CYC (`FPK_DEB_MS * `FPK_CLK_KHZ)
`define FPK_BLINK_MS 250
`define FPK_BLINK_CYC (`FPK_BLINK_MS * `FPK_CLK_KHZ)
`define FPK_BOUT_MS 20
`define FPK_BOUT_CYC (`FPK_BOUT_MS * `FPK_CLK_KHZ)
`define FPK_DCLK_NS 1000
`define FPK_DCLK_CYC (`FPK_DCLK_NS / `FPK_CLK_NS)

// Two-wire bus addresses of the three functions of the block.
`define FPK_KEY_ADDR 7'h20
`define FPK_CTRL_ADDR 7'h21
`define FPK_DISP_ADDR 7'h22

// Lamp and beeper control byte.
`define FPK_LAMP_GRN 1:0
`define FPK_LAMP_YEL 3:2
`define FPK_LAMP_RED 5:4
`define FPK_BEEP_BIT 6
`define FPK_LAMP_RST 7'h00
`define FPK_LMODE_ON 2'h1

// Display control byte.
`define FPK_DCTL_BLANK 0
`define FPK_DCTL_RESET 1
`define FPK_DCTL_RST 2'h0

// Text buffer geometry and control characters.
`define FPK_COLS 40
`define FPK_CHARS 80
`define FPK_CH_CR 8'h0d
`define FPK_CH_LF 8'h0a
`define FPK_CH_SPACE 8'h20

`endif

// ==== design/fpk_debounce.v ====
`timescale 1ns/100ps
`include "fpk_defs.vh"

module fpk_debounce #(
   parameter [19:0] DEB_CYC = `FPK_DEB_CYC
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Raw pin and accepted level
   input wire raw_i,
   output wire stable_o
);

   reg s1_ff;
   reg s2_ff;
   reg stable_ff;
   reg [19:0] cnt_ff;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         stable_ff <= 1'b0;
         cnt_ff <= 20'h00000;
      end else begin
         s1_ff <= raw_i;
         s2_ff <= s1_ff;
         // Contact bounce restarts the count, so only a settled level counts.
         if (s2_ff == stable_ff) begin
            cnt_ff <= 20'h00000;
         end else if (cnt_ff == DEB_CYC - 20'h00001) begin
            stable_ff <= s2_ff;
            cnt_ff <= 20'h00000;
         end else begin
            cnt_ff <= cnt_ff + 20'h00001;
         end
      end
   end

   assign stable_o = stable_ff;

endmodule

// ==== design/fpk_disp.v ====
`timescale 1ns/100ps
`include "fpk_defs.vh"

module fpk_disp #(
   parameter [21:0] BOUT_CYC = `FPK_BOUT_CYC
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Text and commands from the bus side, brown-out from the supply monitor
   input wire chr_stb_i,
   input wire [7:0] chr_i,
   input wire blank_i,
   input wire rst_cmd_i,
   input wire brown_i,
   // Display side
   output wire [7:0] data_o,
   output wire [6:0] addr_o,
   output wire dclk_o,
   output wire blank_o,
   output wire reset_o,
   output wire pwr_o
);

   reg [7:0] mem [0:`FPK_CHARS-1];
   reg [6:0] cur_ff;
   reg [6:0] scan_ff;
   reg [7:0] div_ff;
   reg dclk_ff;
   reg [7:0] data_ff;
   reg [6:0] addr_ff;
   reg brown_d_ff;
   reg pwr_ff;
   reg [21:0] off_ff;
   integer i;

   // Text buffer with a cursor: CR returns to column 0, LF changes row.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cur_ff <= 7'h00;
         for (i = 0; i < `FPK_CHARS; i = i + 1) begin
            mem[i] <= `FPK_CH_SPACE;
         end
      end else if (rst_cmd_i) begin
         cur_ff <= 7'h00;
      end else if (chr_stb_i) begin
         if (chr_i == `FPK_CH_CR) begin
            cur_ff <= (cur_ff < `FPK_COLS) ? 7'h00 : 7'd`FPK_COLS;
         end else if (chr_i == `FPK_CH_LF) begin
            cur_ff <= (cur_ff < `FPK_COLS) ? cur_ff + 7'd`FPK_COLS :
                      cur_ff - 7'd`FPK_COLS;
         end else if (chr_i >= `FPK_CH_SPACE) begin
            mem[cur_ff] <= chr_i;
            cur_ff <= (cur_ff == `FPK_CHARS - 1) ? 7'h00 : cur_ff + 7'h01;
         end
      end
   end

   // Scan clock shared by the decoder and the display.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_ff <= 8'h00;
         dclk_ff <= 1'b0;
         scan_ff <= 7'h00;
         data_ff <= 8'h00;
         addr_ff <= 7'h00;
      end else begin
         if (div_ff == `FPK_DCLK_CYC - 1) begin
            div_ff <= 8'h00;
         end else begin
            div_ff <= div_ff + 8'h01;
         end
         dclk_ff <= (div_ff >= `FPK_DCLK_CYC / 2);
         if (div_ff == 8'h00) begin
            data_ff <= blank_i ? 8'h00 : mem[scan_ff];
            addr_ff <= scan_ff;
            scan_ff <= (scan_ff == `FPK_CHARS - 1) ? 7'h00 : scan_ff + 7'h01;
         end
      end
   end

   // Brown-out recovery: power drops, then returns once the fixed off time has run out and brown-out has cleared.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         brown_d_ff <= 1'b0;
         pwr_ff <= 1'b1;
         off_ff <= 22'h000000;
      end else begin
         brown_d_ff <= brown_i;
         if (brown_i && !brown_d_ff) begin
            pwr_ff <= 1'b0;
            off_ff <= BOUT_CYC;
         end else if (off_ff != 22'h000000) begin
            off_ff <= off_ff - 22'h000001;
         end else if (!brown_i) begin
            pwr_ff <= 1'b1;
         end
      end
   end

   assign data_o = data_ff;
   assign addr_o = addr_ff;
   assign dclk_o = dclk_ff;
   assign blank_o = blank_i;
   assign reset_o = rst_cmd_i;
   assign pwr_o = pwr_ff;

endmodule

// ==== design/fpk_top.v ====
// Overview of operation
// - Key change captures all eight lines unless a press awaits the host.
// - Key word shifts out serially over bus.
// - Key press sets flag that raises interrupt.
// - Key interrupt uses its own dedicated line.
// - Host read acknowledge clears the key flag.
// - Held key gives one event only.
// - Host commands switch lamps and beeper.
// - Switch openings and closings reported to host.
// - Green lamp: off, steady, or blinking.
// - Yellow lamp: off, steady, or blinking.
// - Red lamp blinks on warnings, else off.
// - Serial text goes out as character codes on parallel bus.
// - Text buffer holds two rows of forty.
// - Display clock generated; blank and reset commands.
// - Board lamp lit during maintenance mode.
// - Brown-out turns display off then on.
// - Relay board traffic passes through untouched.
`timescale 1ns/100ps
`include "fpk_defs.vh"

module fpk_top #(
   parameter [19:0] DEB_CYC = `FPK_DEB_CYC,
   parameter [25:0] BLINK_CYC = `FPK_BLINK_CYC,
   parameter [21:0] BOUT_CYC = `FPK_BOUT_CYC
) (
   // Clock and reset
   input wire SYS_CLK_I,
   input wire RST_I,
   // Keypad
   input wire [7:0] KEY_I,
   output wire KEY_INT_O,
   // Two-wire bus, open drain
   input wire SCL_I,
   input wire SDA_I,
   output wire SDA_O,
   output wire SDA_OE_O,
   // Option switches and supply monitor
   input wire MAINT_SW_I,
   input wire LANG_SW_I,
   input wire MAINT_FITTED_I,
   input wire BROWNOUT_I,
   // Lamps and beeper
   output wire LED_SAMPLE_O,
   output wire LED_CAL_O,
   output wire LED_FAULT_O,
   output wire BEEP_O,
   output wire MAINT_LED_O,
   // Display
   output wire [7:0] DISP_DATA_O,
   output wire [6:0] DISP_ADDR_O,
   output wire DISP_CLK_O,
   output wire DISP_BLANK_O,
   output wire DISP_RESET_O,
   output wire DISP_PWR_O
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_AEND = 3'h2;
   localparam [2:0] ST_AHOLD = 3'h3;
   localparam [2:0] ST_WDATA = 3'h4;
   localparam [2:0] ST_RDATA = 3'h5;
   localparam [2:0] ST_RACK = 3'h6;
   localparam [2:0] ST_RNEXT = 3'h7;

   localparam [1:0] TGT_KEY = 2'h0;
   localparam [1:0] TGT_CTRL = 2'h1;
   localparam [1:0] TGT_DISP = 2'h2;

   // Synchronizers: bit 0 SCL, 1 SDA, 2 maint, 3 lang, 4 fitted, 5 brown.
   reg [5:0] s1_ff;
   reg [5:0] s2_ff;
   reg [1:0] bus_d_ff;
   wire scl_s = s2_ff[0];
   wire sda_s = s2_ff[1];
   wire scl_rise = scl_s & ~bus_d_ff[0];
   wire scl_fall = ~scl_s & bus_d_ff[0];
   wire bus_start = scl_s & bus_d_ff[0] & bus_d_ff[1] & ~sda_s;
   wire bus_stop = scl_s & bus_d_ff[0] & ~bus_d_ff[1] & sda_s;

   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s1_ff <= 6'h03;
         s2_ff <= 6'h03;
         bus_d_ff <= 2'h3;
      end else begin
         s1_ff <= {BROWNOUT_I, MAINT_FITTED_I, LANG_SW_I, MAINT_SW_I,
                   SDA_I, SCL_I};
         s2_ff <= s1_ff;
         bus_d_ff <= s2_ff[1:0];
      end
   end

   // Keys.
   wire [7:0] key_s;
   reg [7:0] key_d_ff;
   reg [7:0] key_word_ff;
   reg key_flag_ff;
   reg key_clr;
   genvar g;

   generate
      for (g = 0; g < 8; g = g + 1) begin : g_key
         fpk_debounce #(
            .DEB_CYC(DEB_CYC)
         ) u_deb (
            .clk_i(SYS_CLK_I),
            .rst_i(RST_I),
            .raw_i(KEY_I[g]),
            .stable_o(key_s[g])
         );
      end
   endgenerate

   // A press is a rising debounced level, so a held key fires once.
   wire key_chg = |(key_s ^ key_d_ff);
   wire key_press = |(key_s & ~key_d_ff);
   wire key_cap = key_chg & (~key_flag_ff | key_clr);

   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         key_d_ff <= 8'h00;
         key_word_ff <= 8'h00;
         key_flag_ff <= 1'b0;
      end else begin
         key_d_ff <= key_s;
         // The word is frozen while a press awaits the host.
         if (key_cap) begin
            key_word_ff <= key_s;
         end
         // A new press in the clearing cycle wins over the clear.
         if (key_cap & key_press) begin
            key_flag_ff <= 1'b1;
         end else if (key_clr) begin
            key_flag_ff <= 1'b0;
         end
      end
   end

   assign KEY_INT_O = key_flag_ff;

   // Option switches with sticky change bits.
   reg [1:0] sw_d_ff;
   reg [1:0] sw_chg_ff;
   reg sw_rd;
   wire [1:0] sw_s = s2_ff[3:2];
   wire [1:0] sw_ev = sw_s ^ sw_d_ff;

   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sw_d_ff <= 2'h0;
         sw_chg_ff <= 2'h0;
      end else begin
         sw_d_ff <= sw_s;
         if (sw_rd) begin
            sw_chg_ff <= sw_ev;
         end else begin
            sw_chg_ff <= sw_chg_ff | sw_ev;
         end
      end
   end

   // Bus slave.
   reg [2:0] st_ff;
   reg [7:0] sh_ff;
   reg [2:0] bit_ff;
   reg rw_ff;
   reg [1:0] tgt_ff;
   reg idx_ff;
   reg drv_ff;
   reg [6:0] lamp_cfg_ff;
   reg [1:0] dctl_ff;
   reg chr_stb_ff;
   reg [7:0] chr_ff;
   reg [7:0] rd_byte;
   wire [7:0] in_byte = {sh_ff[6:0], sda_s};

   always @* begin
      rd_byte = 8'h00;
      sw_rd = 1'b0;
      key_clr = 1'b0;
      if (tgt_ff == TGT_KEY) begin
         rd_byte = key_word_ff;
      end else if (tgt_ff == TGT_CTRL) begin
         rd_byte = {4'h0, sw_chg_ff, sw_s};
      end
      if (st_ff == ST_RNEXT || st_ff == ST_AHOLD) begin
         sw_rd = scl_fall & rw_ff & (tgt_ff == TGT_CTRL);
      end
      if (st_ff == ST_RACK) begin
         key_clr = scl_rise & (tgt_ff == TGT_KEY);
      end
   end

   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_ff <= ST_IDLE;
         sh_ff <= 8'h00;
         bit_ff <= 3'h0;
         rw_ff <= 1'b0;
         tgt_ff <= TGT_KEY;
         idx_ff <= 1'b0;
         drv_ff <= 1'b0;
         lamp_cfg_ff <= `FPK_LAMP_RST;
         dctl_ff <= `FPK_DCTL_RST;
         chr_stb_ff <= 1'b0;
         chr_ff <= 8'h00;
      end else begin
         chr_stb_ff <= 1'b0;
         if (bus_start) begin
            st_ff <= ST_ADDR;
            bit_ff <= 3'h0;
            idx_ff <= 1'b0;
            drv_ff <= 1'b0;
         end else if (bus_stop) begin
            st_ff <= ST_IDLE;
            drv_ff <= 1'b0;
         end else begin
            case (st_ff)
               ST_ADDR: begin
                  if (scl_rise) begin
                     sh_ff <= in_byte;
                     bit_ff <= bit_ff + 3'h1;
                     if (bit_ff == 3'h7) begin
                        rw_ff <= sda_s;
                        st_ff <= ST_AEND;
                        if (in_byte[7:1] == `FPK_KEY_ADDR) begin
                           tgt_ff <= TGT_KEY;
                        end else if (in_byte[7:1] == `FPK_CTRL_ADDR) begin
                           tgt_ff <= TGT_CTRL;
                        end else if (in_byte[7:1] == `FPK_DISP_ADDR) begin
                           tgt_ff <= TGT_DISP;
                        end else begin
                           st_ff <= ST_IDLE;
                        end
                     end
                  end
               end
               ST_AEND: begin
                  if (scl_fall) begin
                     drv_ff <= 1'b1;
                     st_ff <= ST_AHOLD;
                  end
               end
               ST_AHOLD: begin
                  if (scl_fall) begin
                     bit_ff <= 3'h0;
                     if (rw_ff) begin
                        sh_ff <= rd_byte;
                        drv_ff <= ~rd_byte[7];
                        st_ff <= ST_RDATA;
                     end else begin
                        drv_ff <= 1'b0;
                        st_ff <= ST_WDATA;
                     end
                  end
               end
               ST_WDATA: begin
                  if (scl_rise) begin
                     sh_ff <= in_byte;
                     bit_ff <= bit_ff + 3'h1;
                     if (bit_ff == 3'h7) begin
                        st_ff <= ST_AEND;
                        idx_ff <= 1'b1;
                        if (tgt_ff == TGT_CTRL && !idx_ff) begin
                           lamp_cfg_ff <= in_byte[6:0];
                        end else if (tgt_ff == TGT_CTRL) begin
                           dctl_ff <= in_byte[1:0];
                        end else if (tgt_ff == TGT_DISP) begin
                           chr_ff <= in_byte;
                           chr_stb_ff <= 1'b1;
                        end
                     end
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_ff == 3'h7) begin
                        drv_ff <= 1'b0;
                        st_ff <= ST_RACK;
                     end else begin
                        bit_ff <= bit_ff + 3'h1;
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        drv_ff <= ~sh_ff[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     st_ff <= sda_s ? ST_IDLE : ST_RNEXT;
                  end
               end
               ST_RNEXT: begin
                  if (scl_fall) begin
                     bit_ff <= 3'h0;
                     sh_ff <= rd_byte;
                     drv_ff <= ~rd_byte[7];
                     st_ff <= ST_RDATA;
                  end
               end
               default: begin
                  drv_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open drain: the pin is only ever pulled low.
   assign SDA_O = 1'b0;
   assign SDA_OE_O = drv_ff;

   // One free-running divider keeps all blinking lamps in step.
   reg [25:0] blink_cnt_ff;
   reg blink_ff;

   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         blink_cnt_ff <= 26'h0000000;
         blink_ff <= 1'b0;
      end else if (blink_cnt_ff == BLINK_CYC - 26'h0000001) begin
         blink_cnt_ff <= 26'h0000000;
         blink_ff <= ~blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 26'h0000001;
      end
   end

   // Lamp codes: 0 off, 1 steady, 2 or 3 blinking; red has no steady.
   reg led_grn_ff;
   reg led_yel_ff;
   reg led_red_ff;
   reg beep_ff;
   reg maint_led_ff;
   wire [1:0] grn_m = lamp_cfg_ff[`FPK_LAMP_GRN];
   wire [1:0] yel_m = lamp_cfg_ff[`FPK_LAMP_YEL];
   wire [1:0] red_m = lamp_cfg_ff[`FPK_LAMP_RED];

   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         led_grn_ff <= 1'b0;
         led_yel_ff <= 1'b0;
         led_red_ff <= 1'b0;
         beep_ff <= 1'b0;
         maint_led_ff <= 1'b0;
      end else begin
         led_grn_ff <= (grn_m == `FPK_LMODE_ON) |
                       (grn_m[1] & blink_ff);
         led_yel_ff <= (yel_m == `FPK_LMODE_ON) |
                       (yel_m[1] & blink_ff);
         led_red_ff <= red_m[1] & blink_ff;
         beep_ff <= lamp_cfg_ff[`FPK_BEEP_BIT];
         maint_led_ff <= s2_ff[4] & s2_ff[2];
      end
   end

   assign LED_SAMPLE_O = led_grn_ff;
   assign LED_CAL_O = led_yel_ff;
   assign LED_FAULT_O = led_red_ff;
   assign BEEP_O = beep_ff;
   assign MAINT_LED_O = maint_led_ff;

   fpk_disp #(
      .BOUT_CYC(BOUT_CYC)
   ) u_disp (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .chr_stb_i(chr_stb_ff),
      .chr_i(chr_ff),
      .blank_i(dctl_ff[`FPK_DCTL_BLANK]),
      .rst_cmd_i(dctl_ff[`FPK_DCTL_RESET]),
      .brown_i(s2_ff[5]),
      .data_o(DISP_DATA_O),
      .addr_o(DISP_ADDR_O),
      .dclk_o(DISP_CLK_O),
      .blank_o(DISP_BLANK_O),
      .reset_o(DISP_RESET_O),
      .pwr_o(DISP_PWR_O)
   );

endmodule

// ==== test/fpk_chk.sv ====
`timescale 1ns/100ps
`include "fpk_defs.vh"

module fpk_chk #(
   parameter [21:0] BOUT_CYC = `FPK_BOUT_CYC
) (
   // Clock and reset
   input wire SYS_CLK_I,
   input wire RST_I,
   // Keys and bus
   input wire [7:0] KEY_I,
   input wire KEY_INT_O,
   input wire SCL_I,
   input wire SDA_O,
   input wire SDA_OE_O,
   // Switches, supply and board lamp
   input wire MAINT_SW_I,
   input wire MAINT_FITTED_I,
   input wire BROWNOUT_I,
   input wire MAINT_LED_O,
   // Display
   input wire [7:0] DISP_DATA_O,
   input wire [6:0] DISP_ADDR_O,
   input wire DISP_CLK_O,
   input wire DISP_BLANK_O,
   input wire DISP_PWR_O
);
   localparam int HALF = `FPK_DCLK_CYC / 2;
   logic [21:0] low_cnt_ff;
   logic [7:0] dclk_cnt_ff;
   logic dclk_prev_ff;
   logic dclk_seen_ff;

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RST_I);

   // Counters let long holds be checked without deep repetitions.
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         low_cnt_ff <= 22'h0;
         dclk_cnt_ff <= 8'h0;
         dclk_prev_ff <= 1'b0;
         dclk_seen_ff <= 1'b0;
      end else begin
         low_cnt_ff <= DISP_PWR_O ? 22'h0 : low_cnt_ff + 22'h1;
         dclk_prev_ff <= DISP_CLK_O;
         if (DISP_CLK_O != dclk_prev_ff) begin
            dclk_cnt_ff <= 8'h1;
            dclk_seen_ff <= 1'b1;
         end else begin
            dclk_cnt_ff <= dclk_cnt_ff + 8'h1;
         end
      end
   end

   AST_SDA_ZERO: assert property (SDA_O == 1'b0)
      else $error("SDA value not zero");
   AST_INT_RISE: assert property ($rose(KEY_INT_O) |->
      $past(KEY_I, 4) != 8'h00) else $error("flag without key");
   AST_INT_FALL: assert property ($fell(KEY_INT_O) |->
      $past(SCL_I, 2)) else $error("flag cleared off bus clock");
   AST_OE_ON_LOW: assert property ($changed(SDA_OE_O) |->
      !$past(SCL_I, 2)) else $error("SDA changed while SCL high");
   AST_MLED_ON: assert property
      ((MAINT_FITTED_I && MAINT_SW_I)[*4] |-> MAINT_LED_O)
      else $error("board lamp not lit");
   AST_MLED_OFF: assert property
      ((!(MAINT_FITTED_I && MAINT_SW_I))[*4] |-> !MAINT_LED_O)
      else $error("board lamp lit");
   AST_PWR_DROP: assert property ($rose(BROWNOUT_I) |->
      ##[1:6] !DISP_PWR_O) else $error("display not switched off");
   AST_PWR_HOLD: assert property ($rose(DISP_PWR_O) |->
      low_cnt_ff >= BOUT_CYC) else $error("display off too short");
   AST_PWR_BACK: assert property (!DISP_PWR_O &&
      low_cnt_ff > BOUT_CYC + 22'h8 |-> $past(BROWNOUT_I, 6))
      else $error("display not back on");
   // Data is reloaded only with each scan step, so blanking shows there.
   AST_BLANK_DATA: assert property ($changed(DISP_ADDR_O) &&
      $past(DISP_BLANK_O) |-> DISP_DATA_O == 8'h00)
      else $error("data while blanked");
   AST_DCLK_HALF: assert property
      ((DISP_CLK_O != dclk_prev_ff) && dclk_seen_ff |-> dclk_cnt_ff == HALF)
      else $error("display clock");
   AST_ADDR_RANGE: assert property (DISP_ADDR_O <= 7'h4f)
      else $error("scan position out of range");
   AST_SCAN_STEP: assert property ($changed(DISP_ADDR_O) |->
      DISP_ADDR_O == (($past(DISP_ADDR_O) == 7'h4f) ? 7'h00 :
      $past(DISP_ADDR_O) + 7'h1)) else $error("scan order");

   COV_KEY: cover property ($rose(KEY_INT_O));
   COV_ACK: cover property ($rose(SDA_OE_O));
   COV_BROWN: cover property ($fell(DISP_PWR_O));
   COV_BLANK: cover property ($rose(DISP_BLANK_O));
endmodule

// ==== test/fpk_host.sv ====
`timescale 1ns/100ps

module fpk_host (
   // Bus wires
   output logic scl_o,
   output logic sda_o,
   input wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // The host alone moves SCL, and only inside frames.
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      #20 scl_o = 1'b1;
      #20 r = sda_i;
      #20 scl_o = 1'b0;
      #20;
   endtask

   // Odd offset keeps the bus phase unrelated to the system clock.
   task automatic start();
      #3.7 sda_o = 1'b1;
      #20 scl_o = 1'b1;
      #20 sda_o = 1'b0;
      #20 scl_o = 1'b0;
      #20;
   endtask

   task automatic stop();
      sda_o = 1'b0;
      #20 scl_o = 1'b1;
      #20 sda_o = 1'b1;
      #20;
   endtask

   // Every frame opens with the target's address byte.
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   // The host answers each key byte, which clears the flag.
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
   typedef logic [7:0] bq_t[$];
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] keys = 8'h00;
   logic maint_sw = 1'b0;
   logic lang_sw = 1'b0;
   logic fitted = 1'b0;
   logic brown = 1'b0;
   logic scl;
   logic host_sda;
   wire sda;
   wire key_int, sda_o, sda_oe, led_s, led_c, led_f, beep, mled;
   wire dclk, dblank, drst, dpwr;
   wire [7:0] ddata;
   wire [6:0] daddr;
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;
   logic [7:0] kw, d, lb;
   logic [7:0] ch [4];
   logic [2:0] hi, lo;
   logic [1:0] cc, e, s, prev;
   logic ack;
   logic [1:0] sw_seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

   // SDA has a pull-up, so a released wire reads high.
   assign sda = host_sda & (sda_oe ? sda_o : 1'b1);

   fpk_top #(.DEB_CYC(20'h4), .BLINK_CYC(26'h8), .BOUT_CYC(22'ha)) i_dut (
      .SYS_CLK_I(clk), .RST_I(rst), .KEY_I(keys), .KEY_INT_O(key_int),
      .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
      .MAINT_SW_I(maint_sw), .LANG_SW_I(lang_sw),
      .MAINT_FITTED_I(fitted), .BROWNOUT_I(brown),
      .LED_SAMPLE_O(led_s), .LED_CAL_O(led_c), .LED_FAULT_O(led_f),
      .BEEP_O(beep), .MAINT_LED_O(mled), .DISP_DATA_O(ddata),
      .DISP_ADDR_O(daddr), .DISP_CLK_O(dclk), .DISP_BLANK_O(dblank),
      .DISP_RESET_O(drst), .DISP_PWR_O(dpwr));

   fpk_host i_host (.scl_o(scl), .sda_o(host_sda), .sda_i(sda));

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic give_verdict();
      if (num_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         num_errors++;
         $display("Error at %0t: timeout", $time);
         give_verdict();
      end
   end

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (!ok) begin
         num_errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic bus_wr(input logic [6:0] a, input bq_t q, output logic k);
      logic x;
      i_host.start();
      i_host.put({a, 1'b0}, k);
      foreach (q[i]) i_host.put(q[i], x);
      i_host.stop();
   endtask

   task automatic bus_rd(input logic [6:0] a, output logic [7:0] v,
                         output logic k);
      i_host.start();
      i_host.put({a, 1'b1}, k);
      if (k) i_host.get(1'b1, v);
      i_host.stop();
   endtask

   // Lamp code to expected look: 0 dark, 1 steady, 2 blinking.
   function automatic logic [1:0] lamp_exp(input logic [1:0] c,
                                           input logic red);
      if (c == 2'h0 || (red && c == 2'h1)) return 2'h0;
      return (c == 2'h1) ? 2'h1 : 2'h2;
   endfunction

   task automatic chk_disp(input logic [6:0] p, input logic [7:0] v);
      n = 0;
      while (daddr !== p && n < 17000) begin
         step(1);
         n++;
      end
      step(2);
      check(ddata === v, "display text");
   endtask

   initial begin
      void'($urandom(55496));
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      step(5);
      keys = 8'h01;
      step(2);
      keys = 8'h00;
      step(40);
      check(key_int === 1'b0, "bounce accepted");
      for (int i = 0; i < 3; i++) begin
         kw = 8'($urandom_range(255, 1));
         keys = kw;
         n = 0;
         while (key_int !== 1'b1 && n < 40) begin
            step(1);
            n++;
         end
         check(key_int === 1'b1, "no key flag");
         bus_rd(7'h20, d, ack);
         check(ack === 1'b1 && d === kw, "key word");
         step(2);
         check(key_int === 1'b0, "flag not cleared");
         step(40);
         check(key_int === 1'b0, "held key repeated");
         keys = 8'h00;
         step(40);
         check(key_int === 1'b0, "release raised flag");
      end
      // Host picks the lamp modes and sends them as codes.
      for (int c = 0; c < 4; c++) begin
         cc = 2'(c);
         lb = {1'b0, cc[0], cc, cc, cc};
         bus_wr(7'h21, '{lb}, ack);
         step(4);
         hi = 3'h0;
         lo = 3'h0;
         repeat (32) begin
            step(1);
            hi = hi | {led_f, led_c, led_s};
            lo = lo | ~{led_f, led_c, led_s};
            if (cc[1]) begin
               check(led_s === led_c && led_c === led_f, "phase");
            end
         end
         for (int l = 0; l < 3; l++) begin
            e = lamp_exp(cc, l == 2);
            check(hi[l] === (e != 2'h0), "lamp");
            check(lo[l] === (e != 2'h1), "lamp");
         end
         check(beep === cc[0], "beeper");
      end
      for (int c = 3; c >= 0; c--) begin
         bus_wr(7'h21, '{8'h00, 8'(c)}, ack);
         step(4);
         check(dblank === c[0] && drst === c[1], "display ctl");
      end
      bus_wr(7'h50, '{8'h3f}, ack);
      step(8);
      check(ack === 1'b0, "relay acked");
      check(led_s === 1'b0 && beep === 1'b0, "relay");
      foreach (ch[i]) ch[i] = 8'h21 + 8'($urandom_range(93));
      bus_wr(7'h22, '{ch[0], ch[1], 8'h01, 8'h0a, ch[2], 8'h0d, ch[3]}, ack);
      chk_disp(7'h00, ch[0]);
      chk_disp(7'h01, ch[1]);
      chk_disp(7'h28, ch[3]);
      chk_disp(7'h2a, ch[2]);
      fitted = 1'b1;
      bus_rd(7'h21, d, ack);
      prev = 2'b00;
      for (int i = 0; i < 4; i++) begin
         s = sw_seq[i];
         {lang_sw, maint_sw} = s;
         step(30);
         bus_rd(7'h21, d, ack);
         check(d === {4'h0, s ^ prev, s}, "switch report");
         check(mled === s[0], "board lamp");
         prev = s;
      end
      brown = 1'b1;
      step(4);
      check(dpwr === 1'b0, "display kept on");
      step(20);
      check(dpwr === 1'b0, "display back too early");
      brown = 1'b0;
      step(8);
      check(dpwr === 1'b1, "display not restored");
      brown = 1'b1;
      step(3);
      brown = 1'b0;
      step(5);
      check(dpwr === 1'b0, "short brown-out ignored");
      step(12);
      check(dpwr === 1'b1, "display stuck off");
      give_verdict();
   end
endmodule

bind fpk_top fpk_chk #(.BOUT_CYC(BOUT_CYC)) i_chk (
   .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .KEY_I(KEY_I),
   .KEY_INT_O(KEY_INT_O), .SCL_I(SCL_I), .SDA_O(SDA_O),
   .SDA_OE_O(SDA_OE_O), .MAINT_SW_I(MAINT_SW_I),
   .MAINT_FITTED_I(MAINT_FITTED_I), .BROWNOUT_I(BROWNOUT_I),
   .MAINT_LED_O(MAINT_LED_O), .DISP_DATA_O(DISP_DATA_O),
   .DISP_ADDR_O(DISP_ADDR_O), .DISP_CLK_O(DISP_CLK_O),
   .DISP_BLANK_O(DISP_BLANK_O), .DISP_PWR_O(DISP_PWR_O));
